// File: hdl/boot_guard_params.svh
`ifndef BOOT_GUARD_PARAMS_SVH
`define BOOT_GUARD_PARAMS_SVH

// register offsets, byte addresses on the wishbone slave
`define GUARD_OFS_CTRL      8'h00
`define GUARD_OFS_LOCK      8'h04
`define GUARD_OFS_STAT      8'h08
`define GUARD_OFS_RVEC      8'h0C

// ctrl fields
`define GUARD_CTRL_IVBOOT   0
`define GUARD_CTRL_RESET    1'b0

// lock register field positions
`define GUARD_LOCK_APP_LO   0
`define GUARD_LOCK_APP_HI   1
`define GUARD_LOCK_BOOT_LO  2
`define GUARD_LOCK_BOOT_HI  3
`define GUARD_LOCK_ERASED   4'hF

// status fields
`define GUARD_STAT_FUSE     0
`define GUARD_STAT_EXECBOOT 1
`define GUARD_STAT_WRCNT_LO 8
`define GUARD_STAT_RDCNT_LO 16

// application reset vector, word address
`define GUARD_APP_RESET     16'h0000

`endif

// File: hdl/boot_guard_pkg.sv
`default_nettype none

package boot_guard_pkg;

  // protection mode of one lock pair, decoded from {high, low}
  typedef enum logic [1:0] {
    lock_free,
    lock_no_write,
    lock_full,
    lock_no_read
  } lock_mode_t;

  typedef struct packed {
    logic wr_block;
    logic rd_block;
    logic irq_hide;
  } lock_perm_t;

endpackage : boot_guard_pkg

`default_nettype wire

// File: hdl/guard_if.sv
`default_nettype none

interface guard_if;
  import boot_guard_pkg::*;

  logic [1:0] app_lock;
  logic [1:0] boot_lock;
  lock_perm_t app_perm;
  lock_perm_t boot_perm;

  modport ctl (
    output app_lock,
    output boot_lock,
    input  app_perm,
    input  boot_perm
  );

  modport dec (
    input  app_lock,
    input  boot_lock,
    output app_perm,
    output boot_perm
  );

endinterface : guard_if

`default_nettype wire

// File: hdl/lock_decode.sv
`default_nettype none

module lock_decode
  import boot_guard_pkg::*;
(
  guard_if.dec gi
);

  // both pairs share one decoding, each pair judged on its own
  function automatic lock_perm_t decode_pair(input logic [1:0] pair);
    lock_mode_t mode;
    lock_perm_t perm;
    unique case (pair)
      2'b11:   mode = lock_free;
      2'b10:   mode = lock_no_write;
      2'b00:   mode = lock_full;
      2'b01:   mode = lock_no_read;
    endcase
    perm.wr_block = (mode == lock_no_write) || (mode == lock_full);
    perm.rd_block = (mode == lock_full) || (mode == lock_no_read);
    perm.irq_hide = (mode == lock_full) || (mode == lock_no_read);
    return perm;
  endfunction : decode_pair

  always_comb begin
    gi.app_perm  = decode_pair(gi.app_lock);
    gi.boot_perm = decode_pair(gi.boot_lock);
  end

endmodule : lock_decode

`default_nettype wire

// File: hdl/boot_section_access_guard.sv
`include "boot_guard_params.svh"
`default_nettype none
module boot_section_access_guard
  import boot_guard_pkg::*;
#(
  parameter int unsigned         PC_W       = 13,
  parameter logic [PC_W-1:0]     BOOT_START = 13'h1C00,
  parameter int unsigned         CNT_W      = 8
)(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  input  wire logic              boot_reset_select_fuse_i,
  input  wire logic [3:0]        lock_nv_i,
  input  wire logic              chip_erase_i,
  input  wire logic [PC_W-1:0]   pc_i,
  input  wire logic              lpm_req_i,
  input  wire logic [PC_W:0]     lpm_addr_i,
  input  wire logic              spm_req_i,
  input  wire logic [PC_W:0]     spm_addr_i,
  output logic      [PC_W-1:0]   reset_vector_o,
  output logic                   lpm_grant_o,
  output logic                   lpm_refuse_o,
  output logic                   spm_start_o,
  output logic                   spm_refuse_o,
  output logic      [PC_W:0]     flash_addr_o,
  output logic                   irq_mask_o
);

  // pin synchronisers; the first stage feeds only the second
  logic [5:0] pin_meta_q;
  logic [5:0] pin_sync_q;

  always_ff @(posedge clk_i) begin
    pin_meta_q <= {chip_erase_i, boot_reset_select_fuse_i, lock_nv_i};
    pin_sync_q <= pin_meta_q;
  end

  logic       erase_sync;
  logic       fuse_sync;
  logic [3:0] lock_sync;
  assign lock_sync  = pin_sync_q[3:0];
  assign fuse_sync  = pin_sync_q[4];
  assign erase_sync = pin_sync_q[5];

  // nonvolatile state and software registers
  logic             fuse_q;
  logic [3:0]       lock_q,     lock_d;
  logic             ivboot_q,   ivboot_d;
  logic             erase_q;
  logic             erase_rise;
  logic             ack_q,      ack_d;
  logic [31:0]      dat_q,      dat_d;
  logic [CNT_W-1:0] wr_cnt_q,   wr_cnt_d;
  logic [CNT_W-1:0] rd_cnt_q,   rd_cnt_d;
  logic             bus_req;
  logic             bus_wr;

  assign erase_rise = erase_sync && !erase_q;
  assign bus_req    = cyc_i && stb_i;
  // a write lands on the edge where the master sees ack
  assign bus_wr     = bus_req && we_i && ack_q && sel_i[0];

  // request decision
  logic            exec_boot;
  logic            spm_tgt_boot;
  logic            lpm_tgt_boot;
  logic            spm_ok;
  logic            lpm_ok;
  logic            spm_go_d,   spm_go_q;
  logic            spm_no_d,   spm_no_q;
  logic            lpm_go_d,   lpm_go_q;
  logic            lpm_no_d,   lpm_no_q;
  logic [PC_W:0]   faddr_d,    faddr_q;
  logic            irq_d,      irq_q;
  logic [PC_W-1:0] rvec_d,     rvec_q;

  function automatic logic in_boot(input logic [PC_W-1:0] word_addr);
    return word_addr >= BOOT_START;
  endfunction : in_boot

  guard_if gi ();

  assign gi.app_lock  = {lock_q[`GUARD_LOCK_APP_HI], lock_q[`GUARD_LOCK_APP_LO]};
  assign gi.boot_lock = {lock_q[`GUARD_LOCK_BOOT_HI], lock_q[`GUARD_LOCK_BOOT_LO]};

  lock_decode u_decode (
    .gi (gi.dec)
  );

  assign exec_boot    = in_boot(pc_i);
  assign spm_tgt_boot = in_boot(spm_addr_i[PC_W:1]);
  assign lpm_tgt_boot = in_boot(lpm_addr_i[PC_W:1]);

  // general lock modes have no input here at all, so they cannot gate
  assign spm_ok = exec_boot
               && !(spm_tgt_boot ? gi.boot_perm.wr_block
                                 : gi.app_perm.wr_block);
  assign lpm_ok = !(lpm_tgt_boot && !exec_boot && gi.boot_perm.rd_block)
               && !(!lpm_tgt_boot && exec_boot && gi.app_perm.rd_block);

  always_comb begin
    spm_go_d = spm_req_i && spm_ok;
    spm_no_d = spm_req_i && !spm_ok;
    lpm_go_d = lpm_req_i && lpm_ok;
    lpm_no_d = lpm_req_i && !lpm_ok;
    faddr_d  = faddr_q;
    // a refused request never puts an address toward the array
    if (spm_go_d) begin
      faddr_d = spm_addr_i;
    end else if (lpm_go_d) begin
      faddr_d = lpm_addr_i;
    end
    irq_d = (gi.app_perm.irq_hide && ivboot_q && !exec_boot)
         || (gi.boot_perm.irq_hide && !ivboot_q && exec_boot);
    rvec_d = fuse_q ? PC_W'(`GUARD_APP_RESET) : BOOT_START;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spm_go_q <= 1'b0;
      spm_no_q <= 1'b0;
      lpm_go_q <= 1'b0;
      lpm_no_q <= 1'b0;
      faddr_q  <= '0;
      irq_q    <= 1'b1;
      rvec_q   <= PC_W'(`GUARD_APP_RESET);
    end else begin
      spm_go_q <= spm_go_d;
      spm_no_q <= spm_no_d;
      lpm_go_q <= lpm_go_d;
      lpm_no_q <= lpm_no_d;
      faddr_q  <= faddr_d;
      irq_q    <= irq_d;
      rvec_q   <= rvec_d;
    end
  end

  // register file and bus slave
  always_comb begin
    lock_d   = lock_q;
    ivboot_d = ivboot_q;
    wr_cnt_d = wr_cnt_q;
    rd_cnt_d = rd_cnt_q;
    ack_d    = bus_req && !ack_q;
    dat_d    = dat_q;
    if (spm_no_q && (wr_cnt_q != '1)) begin
      wr_cnt_d = wr_cnt_q + CNT_W'(1);
    end
    if (lpm_no_q && (rd_cnt_q != '1)) begin
      rd_cnt_d = rd_cnt_q + CNT_W'(1);
    end
    if (bus_req && !ack_q) begin
      dat_d = 32'h0000_0000;
      unique case (adr_i)
        `GUARD_OFS_CTRL: dat_d[`GUARD_CTRL_IVBOOT] = ivboot_q;
        `GUARD_OFS_LOCK: dat_d[3:0] = lock_q;
        `GUARD_OFS_STAT: begin
          dat_d[`GUARD_STAT_FUSE]     = fuse_q;
          dat_d[`GUARD_STAT_EXECBOOT] = exec_boot;
          dat_d[`GUARD_STAT_WRCNT_LO +: CNT_W] = wr_cnt_q;
          dat_d[`GUARD_STAT_RDCNT_LO +: CNT_W] = rd_cnt_q;
        end
        `GUARD_OFS_RVEC: dat_d[PC_W-1:0] = rvec_q;
        default:         dat_d = 32'h0000_0000;
      endcase
    end
    if (bus_wr && (adr_i == `GUARD_OFS_CTRL)) begin
      ivboot_d = dat_i[`GUARD_CTRL_IVBOOT];
    end
    // writes may only program bits low; status and fuse take no write
    if (erase_rise) begin
      lock_d = `GUARD_LOCK_ERASED;
    end else if (bus_wr && (adr_i == `GUARD_OFS_LOCK)) begin
      lock_d = lock_q & dat_i[3:0];
    end
  end

  always_ff @(posedge clk_i) begin
    erase_q <= erase_sync;
    if (rst_i) begin
      // reset must span the synchroniser so the captured pins are settled
      fuse_q   <= fuse_sync;
      lock_q   <= lock_sync;
      ivboot_q <= `GUARD_CTRL_RESET;
      wr_cnt_q <= '0;
      rd_cnt_q <= '0;
      ack_q    <= 1'b0;
      dat_q    <= 32'h0000_0000;
    end else begin
      lock_q   <= lock_d;
      ivboot_q <= ivboot_d;
      wr_cnt_q <= wr_cnt_d;
      rd_cnt_q <= rd_cnt_d;
      ack_q    <= ack_d;
      dat_q    <= dat_d;
    end
  end

  assign ack_o          = ack_q;
  assign dat_o          = dat_q;
  assign reset_vector_o = rvec_q;
  assign spm_start_o    = spm_go_q;
  assign spm_refuse_o   = spm_no_q;
  assign lpm_grant_o    = lpm_go_q;
  assign lpm_refuse_o   = lpm_no_q;
  assign flash_addr_o   = faddr_q;
  assign irq_mask_o     = irq_q;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_lock_write;
    bus_wr && (adr_i == `GUARD_OFS_LOCK) && !erase_rise;
  endsequence

  sequence s_app_store;
    spm_req_i && exec_boot && !spm_tgt_boot;
  endsequence

  sequence s_boot_store;
    spm_req_i && exec_boot && spm_tgt_boot;
  endsequence

  // a load granted in the same cycle may still move the address
  chk_store_from_app: assert property (
    spm_req_i && !exec_boot |=> spm_refuse_o && !spm_start_o
    && (lpm_grant_o || $stable(flash_addr_o)))
    else $error("store from application code was not refused");

  chk_app_store_lock: assert property (
    s_app_store ##0 !lock_q[`GUARD_LOCK_APP_LO] |=> spm_refuse_o && !spm_start_o)
    else $error("store into locked application section started");

  chk_app_store_free: assert property (
    s_app_store ##0 lock_q[`GUARD_LOCK_APP_LO] |=> spm_start_o && flash_addr_o == $past(spm_addr_i))
    else $error("permitted application store did not start");

  chk_boot_store_lock: assert property (
    s_boot_store ##0 (lock_q[`GUARD_LOCK_BOOT_LO] == 1'b0) |=> spm_refuse_o)
    else $error("store into locked boot section started");

  chk_app_read_block: assert property (
    lpm_req_i && exec_boot && !lpm_tgt_boot && !lock_q[`GUARD_LOCK_APP_HI]
    |=> lpm_refuse_o && !lpm_grant_o)
    else $error("boot code read locked application section");

  chk_boot_read_block: assert property (
    lpm_req_i && !exec_boot && lpm_tgt_boot && !lock_q[`GUARD_LOCK_BOOT_HI]
    |=> lpm_refuse_o && !lpm_grant_o)
    else $error("application code read locked boot section");

  chk_lock_no_raise: assert property (
    !erase_rise |=> (lock_q & ~$past(lock_q)) == 4'h0)
    else $error("lock bit returned high without erase");

  chk_lock_program: assert property (
    s_lock_write |=> lock_q == ($past(lock_q) & $past(dat_i[3:0])))
    else $error("lock write did not program selected bits");

  chk_fuse_held: assert property (
    1'b1 |=> $stable(fuse_q) [*4])
    else $error("fuse changed outside reset");

  chk_reset_vector: assert property (
    1'b1 |-> ##1 reset_vector_o == ($past(fuse_q) ? PC_W'(`GUARD_APP_RESET) : BOOT_START))
    else $error("reset vector does not follow fuse");

  chk_irq_app_mask: assert property (
    !lock_q[`GUARD_LOCK_APP_HI] && ivboot_q && !exec_boot |=> irq_mask_o)
    else $error("interrupts open in application code");

  chk_irq_boot_mask: assert property (
    !lock_q[`GUARD_LOCK_BOOT_HI] && !ivboot_q && exec_boot |=> irq_mask_o)
    else $error("interrupts open in boot code");

endmodule : boot_section_access_guard

`default_nettype wire

// File: test/cpu_req_model.sv
`default_nettype none
// core side: one request per call, lines released afterwards show the inverse value
module cpu_req_model (
  input  wire logic        clk_i,
  output var  logic [12:0] pc_o,
  output var  logic        lpm_req_o,
  output var  logic [13:0] lpm_addr_o,
  output var  logic        spm_req_o,
  output var  logic [13:0] spm_addr_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    pc_o = 13'h0000;
    lpm_req_o = 1'b0;
    lpm_addr_o = 14'h0000;
    spm_req_o = 1'b0;
    spm_addr_o = 14'h0000;
  end

  task set_pc(input logic [12:0] pc);
    @(posedge clk_i);
    pc_o <= pc;
  endtask : set_pc

  // returns at the edge that takes the request; answer lands just after it
  task issue(input logic st, input logic [12:0] pc, input logic [13:0] a);
    @(posedge clk_i);
    pc_o <= pc;
    spm_req_o <= st;
    lpm_req_o <= !st;
    spm_addr_o <= a;
    lpm_addr_o <= a;
    @(posedge clk_i);
    spm_req_o <= 1'b0;
    lpm_req_o <= 1'b0;
    spm_addr_o <= ~a;
    lpm_addr_o <= ~a;
  endtask : issue
endmodule : cpu_req_model
`default_nettype wire

// File: test/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [12:0] BOOT = 13'h1C00;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, fuse_pin, erase_i;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i, lock_pin, lk, sw;
  logic [31:0] dat_i, dat_o, d;
  logic ack_o, lg, lr, ss, sr, irq, st, pb, tg, ok;
  logic [12:0] pc, pc_w, rvec;
  logic [13:0] la, sa, fa, a, fa_exp;
  logic lreq, sreq;
  int miscompares, num_checks;
  int wr_ref, rd_ref;
  logic [31:0] rs;

  boot_section_access_guard #(.PC_W(13), .BOOT_START(BOOT), .CNT_W(8))
    u_boot_section_access_guard (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .boot_reset_select_fuse_i(fuse_pin), .lock_nv_i(lock_pin), .chip_erase_i(erase_i),
    .pc_i(pc_w), .lpm_req_i(lreq), .lpm_addr_i(la), .spm_req_i(sreq), .spm_addr_i(sa),
    .reset_vector_o(rvec), .lpm_grant_o(lg), .lpm_refuse_o(lr), .spm_start_o(ss),
    .spm_refuse_o(sr), .flash_addr_o(fa), .irq_mask_o(irq));
  cpu_req_model u_cpu_req_model (.clk_i(clk_i), .pc_o(pc_w), .lpm_req_o(lreq),
    .lpm_addr_o(la), .spm_req_o(sreq), .spm_addr_o(sa));

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle; only the watchdog ends a missing ack
  task wb(input logic w, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] q);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= sw;
    adr_i <= ad;
    dat_i <= wd;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : wb

  task final_report();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    final_report();
  end

  initial begin
    rs = 32'h0000_0060;
    {rst_i, cyc_i, stb_i, we_i, erase_i, fuse_pin} = 6'b100001;
    adr_i = 8'h00;
    sel_i = 4'hF;
    sw = 4'hF;
    wr_ref = 0;
    rd_ref = 0;
    dat_i = 32'h0;
    lock_pin = 4'hF;
    fa_exp = 14'h0000;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1 chk(rvec, 32'h0);
    @(posedge clk_i);
    fuse_pin <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1 chk(rvec, 32'h0);
    wb(1'b0, 8'h0C, 32'h0, d);
    chk(d, 32'h0);
    wb(1'b1, 8'h08, 32'h0, d);
    wb(1'b0, 8'h08, 32'h0, d);
    chk(d[0], 32'h1);
    wb(1'b0, 8'h10, 32'h0, d);
    chk(d, 32'h0);
    for (int v = 0; v < 16; v++) begin
      lk = v[3:0];
      @(posedge clk_i);
      erase_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      erase_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      wb(1'b1, 8'h04, {28'h0, lk}, d);
      wb(1'b1, 8'h04, 32'hF, d);
      wb(1'b0, 8'h04, 32'h0, d);
      chk(d[3:0], lk);
      // a write without byte lane 0 must leave the locks alone
      sw = 4'hE;
      wb(1'b1, 8'h04, 32'h0, d);
      sw = 4'hF;
      wb(1'b0, 8'h04, 32'h0, d);
      chk(d[3:0], lk);
      for (int k = 0; k < 8; k++) begin
        d = rnd();
        st = k[0];
        pc = d[12:0];
        a = d[26:13];
        if (k[1]) pc[12:10] = 3'b111;
        if (k[2]) a[13:11] = 3'b111;
        pb = pc >= BOOT;
        tg = a[13:1] >= BOOT;
        if (st) ok = pb && (tg ? lk[2] : lk[0]);
        else ok = tg ? (pb || lk[3]) : (!pb || lk[1]);
        u_cpu_req_model.issue(st, pc, a);
        if (ok) fa_exp = a;
        if (st && !ok) wr_ref++;
        if (!st && !ok) rd_ref++;
        #1 chk({ss, sr, lg, lr}, {28'h0, st && ok, st && !ok, !st && ok, !st && !ok});
        chk(fa, fa_exp);
      end
      // refused counters settle two cycles after the last request
      wb(1'b0, 8'h08, 32'h0, d);
      chk(d[23:8], {rd_ref[7:0], wr_ref[7:0]});
      chk(d[1], pb);
      for (int iv = 0; iv < 2; iv++) begin
        wb(1'b1, 8'h00, iv, d);
        wb(1'b0, 8'h00, 32'h0, d);
        chk(d[0], iv[0]);
        for (int p = 0; p < 2; p++) begin
          u_cpu_req_model.set_pc(p ? BOOT : 13'h0100);
          repeat (2) @(posedge clk_i);
          ok = (!lk[1] && iv == 1 && p == 0) || (!lk[3] && iv == 0 && p == 1);
          #1 chk(irq, ok);
        end
      end
    end
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1 chk(rvec, BOOT);
    wb(1'b0, 8'h0C, 32'h0, d);
    chk(d, BOOT);
    final_report();
  end
endmodule : tb
`default_nettype wire
